// ===== core/srd_pkg.sv
/*
 * srd_pkg: constants and types for the sysref divider and power control block.
 * assumes a single 100 MHz system clock; the divider input is a clock-enable pulse.
 */
package srd_pkg;

    // ------------------------------------------------------------------
    // register layout and reset values
    // ------------------------------------------------------------------
    localparam int unsigned RATIO_W            = 7;
    localparam logic        POWER_DOWN_RESET   = 1'h0;
    localparam logic [6:0]  RATIO_RESET        = 7'h2f;

    // field positions inside the ratio setting
    localparam int unsigned FIRST_BIT          = 6;
    localparam int unsigned SECOND_HI          = 5;
    localparam int unsigned SECOND_LO          = 4;
    localparam int unsigned THIRD_HI           = 3;
    localparam int unsigned THIRD_LO           = 2;
    localparam int unsigned LAST_HI            = 1;
    localparam int unsigned LAST_LO            = 0;

    // ------------------------------------------------------------------
    // stage counters
    // ------------------------------------------------------------------
    localparam int unsigned STAGE_CNT_W        = 4;   // largest stage ratio is 16
    localparam int unsigned TOTAL_W            = 13;  // largest total is 4*16*16*5 = 5120

    localparam logic [3:0]  DIV_2              = 4'h2;
    localparam logic [3:0]  DIV_3              = 4'h3;
    localparam logic [3:0]  DIV_4              = 4'h4;
    localparam logic [3:0]  DIV_5              = 4'h5;
    localparam logic [3:0]  DIV_8              = 4'h8;
    localparam logic [3:0]  DIV_16             = 4'hf;  // holds 15; decode takes sixteen from DIV_16_FULL, not from this
    localparam logic [4:0]  DIV_16_FULL        = 5'h10;

    // configuration carried as one struct
    typedef struct packed {
        logic              power_down;
        logic [6:0]        ratio;
    } srd_cfg_t;

endpackage

// ===== core/srd_divider.sv
/*
 * srd_divider: sysref power control and four-stage cascaded frequency divider.
 * assumes the divider input clock arrives as a one-cycle enable (CLK_IN_EN) on CLK,
 * and that configuration settings are written by a register port outside this block.
 */
`timescale 1ns/1ns

// How it works
// RULE_01: power-down 1 stops all sysref logic; 0 keeps it running. Code stops counters and outputs only; settings and TOTAL_RATIO still update.
// RULE_02: four cascaded stages; total ratio is product of stage ratios.
// RULE_03: first stage bit 6: 0 divides by 2, 1 by 4.
// RULE_04: middle fields 5:4 and 3:2 give 2, 4, 8, 16 for codes 0..3.
// RULE_05: last field 1:0 gives 2, 3, 4, 5 for codes 0..3.
// RULE_06: software should favour large ratios in late stages when totals tie.
// RULE_07: output period is total ratio times input period; held idle while down. SYSREF_PULSE has that period; SYSREF_OUT toggles, period twice the total.
module srd_divider (
    // clock and reset
    input  wire  logic              CLK,
    input  wire  logic              SYS_RST,
    // configuration write port
    input  wire  logic              CFG_WE,
    input  wire  srd_pkg::srd_cfg_t CFG_WDATA,
    output       srd_pkg::srd_cfg_t CFG_RDATA,
    // divider input and output
    input  wire  logic              CLK_IN_EN,
    output       logic              SYSREF_OUT,
    output       logic              SYSREF_PULSE,
    output       logic              SYSREF_ACTIVE,
    output       logic [srd_pkg::TOTAL_W-1:0] TOTAL_RATIO
);
    import srd_pkg::*;

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    srd_cfg_t cfg_q, cfg_d;
    // active flag taken from the next settings, so it follows a write at once
    logic     active_q, active_d;

    // write replaces both settings at once
    always_comb begin
        cfg_d = cfg_q;
        if (CFG_WE) begin
            cfg_d = CFG_WDATA;
        end
        active_d = ~cfg_d.power_down;                                 // RULE_01
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cfg_q    <= '{power_down: POWER_DOWN_RESET, ratio: RATIO_RESET};
            active_q <= ~POWER_DOWN_RESET;
        end else begin
            cfg_q    <= cfg_d;
            active_q <= active_d;
        end
    end

    assign CFG_RDATA = cfg_q;

    // ------------------------------------------------------------------
    // stage ratio decode
    // ------------------------------------------------------------------
    localparam int unsigned STAGES = 4;   // four serial stages, fixed by the ratio layout

    logic [4:0] r1, r2, r3, r4;
    logic       first_stage_ratio_bit;
    logic [1:0] second_stage_ratio_field;
    logic [1:0] third_stage_ratio_field;
    logic [1:0] last_stage_ratio_field;

    assign first_stage_ratio_bit    = cfg_q.ratio[FIRST_BIT];
    assign second_stage_ratio_field = cfg_q.ratio[SECOND_HI:SECOND_LO];
    assign third_stage_ratio_field  = cfg_q.ratio[THIRD_HI:THIRD_LO];
    assign last_stage_ratio_field   = cfg_q.ratio[LAST_HI:LAST_LO];

    // first stage: one bit picks two or four; the ratio is kept five bits
    // wide like the others so all stages share one counter shape
    function automatic logic [4:0] first_ratio(input logic code);
        logic [4:0] r;
        r = code ? {1'b0, DIV_4} : {1'b0, DIV_2};
        return r;
    endfunction

    // middle stages: powers of two from two to sixteen
    function automatic logic [4:0] mid_ratio(input logic [1:0] code);
        logic [4:0] r;
        unique case (code)
            2'h0:    r = {1'b0, DIV_2};
            2'h1:    r = {1'b0, DIV_4};
            2'h2:    r = {1'b0, DIV_8};
            default: r = DIV_16_FULL;
        endcase
        return r;
    endfunction

    // last stage: two to five in steps of one, the only odd ratios
    function automatic logic [4:0] last_ratio(input logic [1:0] code);
        logic [4:0] r;
        unique case (code)
            2'h0:    r = {1'b0, DIV_2};
            2'h1:    r = {1'b0, DIV_3};
            2'h2:    r = {1'b0, DIV_4};
            default: r = {1'b0, DIV_5};
        endcase
        return r;
    endfunction

    // product of the four stages for one setting; each stage is at most five
    // bits, so twenty bits hold the product and the cut to the total is exact
    function automatic logic [TOTAL_W-1:0] total_of(input logic [RATIO_W-1:0] ratio);
        logic [19:0] full;
        full = 20'(first_ratio(ratio[FIRST_BIT]))
             * 20'(mid_ratio(ratio[SECOND_HI:SECOND_LO]))
             * 20'(mid_ratio(ratio[THIRD_HI:THIRD_LO]))
             * 20'(last_ratio(ratio[LAST_HI:LAST_LO]));
        return full[TOTAL_W-1:0];
    endfunction

    // per-stage ratio from its field
    always_comb begin
        r1 = first_ratio(first_stage_ratio_bit);                      // RULE_03
        r2 = mid_ratio(second_stage_ratio_field);                     // RULE_04
        r3 = mid_ratio(third_stage_ratio_field);                      // RULE_04
        r4 = last_ratio(last_stage_ratio_field);                      // RULE_05
    end

    // total shown for software, decoded from the next settings and registered,
    // so the port comes from a flop yet changes in the same cycle as the
    // stored settings; costs a second decode of the ratio fields
    logic [TOTAL_W-1:0] total_q, total_d;

    always_comb begin
        total_d = total_of(cfg_d.ratio);                              // RULE_02
    end

    // reset loads the total of the default ratio setting
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            total_q <= total_of(RATIO_RESET);
        end else begin
            total_q <= total_d;
        end
    end

    assign TOTAL_RATIO = total_q;

    // ------------------------------------------------------------------
    // cascaded stages: each stage counts the carry of the one before
    // ------------------------------------------------------------------
    // a ratio lowered mid-count can leave a counter above its new limit; the
    // compare below is >= so that counter still wraps on its next carry
    logic [4:0] cnt_q [STAGES];
    logic [4:0] cnt_d [STAGES];
    logic [4:0] ratio_v [STAGES];
    logic       carry [STAGES+1];
    logic       out_q, out_d;

    assign ratio_v[0] = r1;
    assign ratio_v[1] = r2;
    assign ratio_v[2] = r3;
    assign ratio_v[3] = r4;

    // the input enable ripples through; the last carry marks one full period
    always_comb begin
        carry[0] = CLK_IN_EN & ~cfg_q.power_down;                     // RULE_01
        for (int i = 0; i < STAGES; i++) begin
            cnt_d[i]   = cnt_q[i];
            carry[i+1] = 1'b0;
            if (carry[i]) begin                                       // RULE_02
                if (cnt_q[i] >= ratio_v[i] - 5'h1) begin
                    cnt_d[i]   = '0;
                    carry[i+1] = 1'b1;
                end else begin
                    cnt_d[i] = cnt_q[i] + 5'h1;
                end
            end
            if (cfg_q.power_down) begin
                cnt_d[i] = '0;                                        // RULE_07
            end
        end
    end

    // the output flop toggles once per full count, so its period is twice the
    // total; the pulse flop below carries the period equal to the total ratio
    always_comb begin
        out_d = out_q;
        if (cfg_q.power_down) begin
            out_d = 1'b0;                                             // RULE_07
        end else if (carry[4]) begin
            out_d = ~out_q;
        end
    end

    // counters and output flop only register here
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            for (int i = 0; i < STAGES; i++) begin
                cnt_q[i] <= '0;
            end
            out_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // pulse flop: high for the one cycle after each full count
    logic pulse_q;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= carry[4];                                      // RULE_07
        end
    end

    assign SYSREF_OUT    = out_q;
    assign SYSREF_PULSE  = pulse_q;
    assign SYSREF_ACTIVE = active_q;                                  // RULE_01

endmodule

// ===== testbench/srd_divider_props.sv
/* srd_divider_props: port assertions for the sysref divider.
   assumes a bind to srd_divider, one clock, reset active high. */
`timescale 1ns/1ns
module srd_divider_props
import srd_pkg::*;
(
    // clock and reset
    input wire logic        CLK,
    input wire logic        SYS_RST,
    // settings
    input wire logic        CFG_WE,
    input wire srd_cfg_t    CFG_WDATA,
    input wire srd_cfg_t    CFG_RDATA,
    // divider
    input wire logic        CLK_IN_EN,
    input wire logic        SYSREF_OUT,
    input wire logic        SYSREF_PULSE,
    input wire logic        SYSREF_ACTIVE,
    input wire logic [TOTAL_W-1:0] TOTAL_RATIO
);
// ----
// period tracking
// ----
logic [13:0] cnt_q, cnt_d;
logic        clean_q, clean_d;
// a write mid-count leaves that period unmeasurable, so it is skipped
always_comb begin
    cnt_d = SYSREF_PULSE ? 14'(CLK_IN_EN) : cnt_q + 14'(CLK_IN_EN);
    if (CFG_RDATA.power_down) begin
        cnt_d = '0;
    end
    clean_d = ((clean_q | SYSREF_PULSE) & ~CFG_WE) | CFG_RDATA.power_down;
end
// registers only
always_ff @(posedge CLK) begin
    cnt_q   <= SYS_RST ? '0 : cnt_d;
    clean_q <= SYS_RST | clean_d;
end
default clocking @(posedge CLK); endclocking
default disable iff (SYS_RST);
AST_RESET_VALUE: assert property ($fell(SYS_RST) |-> CFG_RDATA == {1'b0, RATIO_RESET})
    else $error("settings differ from defaults");
AST_CFG_WRITE: assert property (CFG_WE |=> CFG_RDATA == $past(CFG_WDATA))
    else $error("write not stored");
AST_ACTIVE: assert property (SYSREF_ACTIVE == !CFG_RDATA.power_down)
    else $error("active flag wrong");
AST_PD_IDLE: assert property (CFG_RDATA.power_down [*2] |-> !SYSREF_OUT && !SYSREF_PULSE)
    else $error("output moves while down");
AST_TOTAL: assert property (TOTAL_RATIO == (CFG_RDATA.ratio[6] ? 4 : 2) *
    (2 << CFG_RDATA.ratio[5:4]) * (2 << CFG_RDATA.ratio[3:2]) * (2 + CFG_RDATA.ratio[1:0]))
    else $error("total ratio wrong");
AST_PERIOD: assert property (SYSREF_PULSE && clean_q |-> cnt_q == TOTAL_RATIO)
    else $error("pulse period wrong");
AST_PULSE_DUE: assert property (clean_q |-> cnt_q <= TOTAL_RATIO)
    else $error("pulse overdue");
AST_TOGGLE: assert property (SYSREF_PULSE |-> SYSREF_OUT != $past(SYSREF_OUT))
    else $error("output did not toggle");
AST_PULSE_ONE: assert property (SYSREF_PULSE |=> !SYSREF_PULSE)
    else $error("pulse too long");
cover property (SYSREF_PULSE && clean_q);
cover property (CFG_RDATA.power_down [*2]);
cover property ($rose(SYSREF_OUT));
endmodule
bind srd_divider srd_divider_props srd_divider_props_inst (.CLK(CLK), .SYS_RST(SYS_RST),
    .CFG_WE(CFG_WE), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .CLK_IN_EN(CLK_IN_EN),
    .SYSREF_OUT(SYSREF_OUT), .SYSREF_PULSE(SYSREF_PULSE), .SYSREF_ACTIVE(SYSREF_ACTIVE),
    .TOTAL_RATIO(TOTAL_RATIO));

// ===== testbench/srd_divider_tb.sv
/* srd_divider_tb: directed checks of settings, ratio decode, period and power-down.
   assumes srd_pkg and the checker are compiled first. */
`timescale 1ns/1ns
module srd_divider_tb;
import srd_pkg::*;
logic        clk = 0, rst = 1, we = 0, en = 0, gap = 0, so, sp, act;
srd_cfg_t    wd = '0, rd;
logic [TOTAL_W-1:0] total;
int          miscompares = 0, checks = 0, n;
srd_divider srd_divider_inst (.CLK(clk), .SYS_RST(rst), .CFG_WE(we), .CFG_WDATA(wd),
    .CFG_RDATA(rd), .CLK_IN_EN(en), .SYSREF_OUT(so), .SYSREF_PULSE(sp),
    .SYSREF_ACTIVE(act), .TOTAL_RATIO(total));
// ----
// clock, enable source, helpers
// ----
always #5 clk = ~clk;
// gap halves the enable rate so counting enables differs from counting cycles
always @(posedge clk) en <= gap ? ~en : 1'b1;
task check(input logic [TOTAL_W-1:0] seen, input logic [TOTAL_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
        miscompares++;
        $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
endtask
task print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
endtask
task wr(input srd_cfg_t v);
    @(posedge clk) we <= 1'b1;
    wd <= v;
    @(posedge clk) we <= 1'b0;
    #1;
endtask
// cycles until the next pulse, bounded
task wait_pulse();
    n = 0;
    do begin
        @(posedge clk) #1;
        n++;
        if (n > 2000) begin
            miscompares++;
            print_verdict();
        end
    end while (sp !== 1'b1);
endtask
// ----
// scenarios
// ----
task t_decode();
    check(rd, {1'b0, RATIO_RESET});
    check(total, 13'd1280);
    wr(8'h1d);
    check(total, 13'd384);
    wr(8'h7f);
    check(total, 13'd5120);
    for (int i = 0; i < 4; i++) begin
        wr({1'b0, i[0], 6'h00});
        check(total, 13'((2 << i[0]) * 8));
        wr({2'h0, i[1:0], 4'h0});
        check(total, 13'((2 << i) * 8));
        wr({4'h0, i[1:0], 2'h0});
        check(total, 13'((2 << i) * 8));
        wr({6'h00, i[1:0]});
        check(total, 13'((2 + i) * 8));
    end
    $display("decode test done");
endtask
task t_pd();
    wr(8'h80);
    check(act, 1'b0);
    n = 0;
    repeat (40) begin
        @(posedge clk) #1;
        n += (sp | so);
    end
    check(n, 0);
    wr(8'h00);
    wait_pulse();
    check(n, 16);
    $display("power-down test done");
endtask
task t_period();
    gap = 1;
    wait_pulse();
    wait_pulse();
    check(n, 32);
    check(act, 1'b1);
    // odd last stage and four-way first stage: 4*2*2*5 enables, half rate
    wr(8'h43);
    wait_pulse();
    wait_pulse();
    check(n, 160);
    $display("period test done");
endtask
initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_decode();
    t_pd();
    t_period();
    print_verdict();
end
endmodule
